// [design/asimpb_pkg.sv]
// Constants and types shared by the AS-i master physical bridge
package asimpb_pkg;

    // System clock
    localparam int CLK_PERIOD_NS = 10;

    // Operating modes, one-hot
    typedef enum logic [2:0] {
        MODE_MASTER1 = 3'b001,
        MODE_MASTER2 = 3'b010,
        MODE_REPEATER = 3'b100
    } asimpb_mode_type;

    // Configuration carried as one bundle
    typedef struct packed {
        logic masterEnable;
        asimpb_mode_type mode;
    } asimpb_cfg_type;

    // Power-fail sequencer states, one-hot
    typedef enum logic [3:0] {
        PF_IDLE = 4'b0001,
        PF_RXMOD = 4'b0010,
        PF_HOLD = 4'b0100,
        PF_RELEASE = 4'b1000
    } asimpb_pf_type;

    // Loopback delay register
    localparam logic [3:0] LB_CODE_RESET = 4'h0;
    localparam int LB_STEP_NS = 125;
    localparam int LB_BASE_NS = 3880;
    localparam int LB_BASE_CYC = LB_BASE_NS / CLK_PERIOD_NS;
    localparam int LB_LINE_LEN = 600;

    // Manchester timing: half bit 3 us, tolerance 0.75 us
    localparam int HALF_NS = 3000;
    localparam int JIT_NS = 750;
    localparam int HALF_CYC = HALF_NS / CLK_PERIOD_NS;
    localparam int FULL_CYC = 2 * HALF_CYC;
    localparam int HALF_MIN_CYC = (HALF_NS - JIT_NS) / CLK_PERIOD_NS;
    localparam int HALF_MAX_CYC = (HALF_NS + JIT_NS) / CLK_PERIOD_NS;
    localparam int FULL_MIN_CYC = (2 * HALF_NS - JIT_NS) / CLK_PERIOD_NS;
    localparam int FULL_MAX_CYC = (2 * HALF_NS + JIT_NS) / CLK_PERIOD_NS;
    localparam int RESYNC_LAT_NS = 1000;
    localparam int RESYNC_LAT_CYC = RESYNC_LAT_NS / CLK_PERIOD_NS;
    localparam int BREAK_NS = 12000;
    localparam int BREAK_CYC = BREAK_NS / CLK_PERIOD_NS;
    localparam int TX_IDLE_NS = 12000;
    localparam int TX_IDLE_CYC = TX_IDLE_NS / CLK_PERIOD_NS;

    // Power-fail timing
    localparam int PF_FILT_NS = 6000;
    localparam int PF_FILT_CYC = (PF_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PF_RX_US = 672;
    localparam int PF_APF_US = 736;
    localparam int PF_HOLD_US = 64;
    localparam int PF_OFF_US = 96;
    localparam int PF_RX_CYC = PF_RX_US * 1000 / CLK_PERIOD_NS - PF_FILT_CYC;
    localparam int PF_APF_CYC = PF_APF_US * 1000 / CLK_PERIOD_NS - PF_FILT_CYC;
    localparam int PF_HOLD_CYC = PF_HOLD_US * 1000 / CLK_PERIOD_NS;
    localparam int PF_OFF_CYC = PF_OFF_US * 1000 / CLK_PERIOD_NS - PF_FILT_CYC;
    localparam int PF_CNT_W = 17;
    localparam int UNUSED_PINS = 8;

endpackage

// [design/asimpb_bridge.sv]
// AS-i master/repeater physical bridge: line pass-through, resync, power fail
//
// Functional notes
// - Mode sets modulation, loopback and receive polarity
// - Check telegrams, re-time edges within jitter limits
// - Telegram error blanks receive output for 12 us
// - Transmit input goes straight to line driver
// - No loopback: receiver off while transmitting
// - Loopback: own transmit signal appears on receive
// - Delay code adds 125 ns per step
// - Code written first; master flag refuses writes
// - First filter drops states shorter than 6 us
// - Second stage: separate assert and release times
// - Power fail output is active high
// - Master mode one drives receive high on power fail
// - Receive power fail after 672 us
// - Power fail output after 736 us
// - Hold needs 64 us more, else idle
// - Hold keeps indication at least 64 us
// - Release 96 us after power returns
// - Loopback edge delay 4.9 to 6.8 us
// - Unused pins held high, not driven
`timescale 1ns/1ps
`default_nettype none

module asimpb_bridge
    import asimpb_pkg::*;
#(
    parameter int PfRxCyc = PF_RX_CYC,
    parameter int PfApfCyc = PF_APF_CYC,
    parameter int PfHoldCyc = PF_HOLD_CYC,
    parameter int PfOffCyc = PF_OFF_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ext_reset_low,
    // Configuration
    input wire asimpb_cfg_type cfgIn,
    input wire logic delayWrite,
    input wire logic [3:0] delay_code_bits,
    output logic [3:0] loopback_delay_setting,
    output logic writeRefused,
    // Line side
    input wire logic transmit_line_in,
    output logic lineTxOut,
    input wire logic lineRxIn,
    output logic lineRxEnable,
    input wire logic line_positive_input,
    // Controller side
    output logic receive_line_out,
    output logic line_power_fail_out,
    // Unused pins, three-signal form
    input wire logic [UNUSED_PINS-1:0] unusedPinIn,
    output logic [UNUSED_PINS-1:0] unusedPinOut,
    output logic [UNUSED_PINS-1:0] unusedPinOe
);

    // Synchroniser stages; stage one only feeds stage two
    logic extRstMeta, extRstSync;
    logic rxMeta, rxSync;
    logic txMeta, txSync;
    logic pfMeta, pfSync;

    // Two-flop capture of every asynchronous input
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            extRstMeta <= 1'b0;
            extRstSync <= 1'b0;
            rxMeta <= 1'b0;
            rxSync <= 1'b0;
            txMeta <= 1'b0;
            txSync <= 1'b0;
            pfMeta <= 1'b0;
            pfSync <= 1'b0;
        end else begin
            extRstMeta <= ext_reset_low;
            extRstSync <= extRstMeta;
            rxMeta <= lineRxIn;
            rxSync <= rxMeta;
            txMeta <= transmit_line_in;
            txSync <= txMeta;
            pfMeta <= line_positive_input;
            pfSync <= pfMeta;
        end
    end

    // Functional reset: system reset or external pin held low
    wire rstAll = !reset_n || !extRstSync;

    // Direct pass to the transmitter; any flop here would add delay
    assign lineTxOut = transmit_line_in;

    // Mode decode; modulation and loopback only while master function is enabled
    wire active = cfgIn.masterEnable;
    wire modMode = active && (cfgIn.mode == MODE_MASTER1);
    wire loopOn = active && (cfgIn.mode != MODE_REPEATER);
    wire invertRx = (cfgIn.mode == MODE_REPEATER);

    // Delay code register, frozen once master flag is set
    logic [3:0] delayCode;
    wire acceptWrite = delayWrite && !cfgIn.masterEnable;

    // Store code; report refused writes for one cycle
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            delayCode <= LB_CODE_RESET;
            writeRefused <= 1'b0;
        end else begin
            if (acceptWrite) begin
                delayCode <= delay_code_bits;
            end
            writeRefused <= delayWrite && cfgIn.masterEnable;
        end
    end

    // Transmit activity: edges keep a retrigger timer alive
    logic txPrev;
    logic [10:0] txIdleCnt;
    wire txEdge = txSync != txPrev;
    wire transmitting = txIdleCnt != 11'h000;

    // Retriggerable activity timer
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            txPrev <= 1'b0;
            txIdleCnt <= 11'h000;
        end else begin
            txPrev <= txSync;
            if (txEdge) begin
                txIdleCnt <= 11'(TX_IDLE_CYC);
            end else if (transmitting) begin
                txIdleCnt <= txIdleCnt - 11'h001;
            end
        end
    end

    // Loopback delay line; tap picks base plus 125 ns steps
    logic [LB_LINE_LEN-1:0] txLine;
    wire [9:0] stepCyc = 10'((32'(delayCode) * LB_STEP_NS) / CLK_PERIOD_NS);
    wire [9:0] tapIdx = 10'(LB_BASE_CYC) + stepCyc;
    wire txDelayed = txLine[tapIdx];

    // Shift every cycle; the tap selects the extra delay
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            txLine <= '0;
        end else begin
            txLine <= {txLine[LB_LINE_LEN-2:0], txSync};
        end
    end

    // A fresh tx edge counts at once: our own pin copy reaches rxSync as early
    wire txActive = transmitting || txEdge;
    // Receiver gating and source select
    wire rxGate = !(txActive && !loopOn);
    // Disabled receiver output is junk; trust it only once the enable
    // has been back for longer than the synchroniser depth
    logic [2:0] rxOnHist;
    wire rxTrusted = rxGate && (rxOnHist == 3'h7);
    wire srcLevel = (loopOn && txActive) ? txDelayed : (rxTrusted && rxSync);

    // Enable history, shifted every cycle
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            rxOnHist <= 3'h7;
        end else begin
            rxOnHist <= {rxOnHist[1:0], lineRxEnable};
        end
    end

    // Edge checker and retimer state
    logic srcPrev;
    logic inTelegram;
    logic [10:0] inCnt;
    logic [10:0] outCnt;
    logic [10:0] target;
    logic pending;
    logic outLevel;
    logic [10:0] breakCnt;
    wire srcEdge = (srcLevel != srcPrev) && (breakCnt == 11'h000);
    wire isHalf = inCnt >= 11'(HALF_MIN_CYC) && inCnt <= 11'(HALF_MAX_CYC);
    wire isFull = inCnt >= 11'(FULL_MIN_CYC) && inCnt <= 11'(FULL_MAX_CYC);
    wire badEdge = srcEdge && inTelegram && !isHalf && !isFull;
    wire timeOut = inTelegram && (inCnt > 11'(FULL_MAX_CYC));
    wire emit = pending && (outCnt >= target);

    // Interval measure, error blanking and nominal re-timing
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            srcPrev <= 1'b0;
            inTelegram <= 1'b0;
            inCnt <= 11'h000;
            outCnt <= 11'h000;
            target <= 11'h000;
            pending <= 1'b0;
            outLevel <= 1'b0;
            breakCnt <= 11'h000;
        end else begin
            srcPrev <= srcLevel;
            // Saturating counters
            if (inCnt != 11'h7ff) begin
                inCnt <= inCnt + 11'h001;
            end
            if (outCnt != 11'h7ff) begin
                outCnt <= outCnt + 11'h001;
            end
            if (breakCnt != 11'h000) begin
                breakCnt <= breakCnt - 11'h001;
            end
            if (badEdge) begin
                // Error: force inactive for the break time
                breakCnt <= 11'(BREAK_CYC);
                outLevel <= 1'b0;
                pending <= 1'b0;
                inTelegram <= 1'b0;
            end else if (srcEdge) begin
                inCnt <= 11'h000;
                pending <= 1'b1;
                if (!inTelegram) begin
                    // First edge: fixed latency absorbs later jitter
                    inTelegram <= 1'b1;
                    outCnt <= 11'h000;
                    target <= 11'(RESYNC_LAT_CYC);
                end else begin
                    // Snap to nominal half or full bit spacing
                    target <= isHalf ? 11'(HALF_CYC) : 11'(FULL_CYC);
                end
            end else begin
                if (timeOut) begin
                    inTelegram <= 1'b0;
                end
                if (emit) begin
                    outLevel <= !outLevel;
                    outCnt <= 11'h000;
                    pending <= 1'b0;
                end
            end
        end
    end

    // Power fail first filter: new level must stay 6 us
    logic pfStage1;
    logic [9:0] filtCnt;

    // Accept a change only after it has held long enough
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            pfStage1 <= 1'b0;
            filtCnt <= 10'h000;
        end else if (pfSync == pfStage1) begin
            filtCnt <= 10'h000;
        end else if (filtCnt == 10'(PF_FILT_CYC - 1)) begin
            pfStage1 <= pfSync;
            filtCnt <= 10'h000;
        end else begin
            filtCnt <= filtCnt + 10'h001;
        end
    end

    // Second stage sequencer with separate on and off times
    asimpb_pf_type pfState, next_pfState;
    logic [PF_CNT_W-1:0] pfCnt;
    logic [PF_CNT_W-1:0] next_pfCnt;
    wire rxHit = pfCnt >= PF_CNT_W'(PfRxCyc - 1);
    wire apfHit = pfCnt >= PF_CNT_W'(PfApfCyc - 1);
    wire holdDone = pfCnt >= PF_CNT_W'(PfHoldCyc - 1);
    wire offDone = pfCnt >= PF_CNT_W'(PfOffCyc - 1);
    wire [PF_CNT_W-1:0] pfCntInc = pfCnt + PF_CNT_W'(1);

    // Next-state logic of the power-fail sequencer
    always_comb begin
        next_pfState = pfState;
        next_pfCnt = pfCntInc;
        case (pfState)
            PF_IDLE: begin
                if (!pfStage1) begin
                    next_pfCnt = '0;
                end else if (rxHit) begin
                    next_pfState = PF_RXMOD;
                end
            end
            PF_RXMOD: begin
                if (!pfStage1) begin
                    // Too short for hold: straight back to idle
                    next_pfState = PF_IDLE;
                    next_pfCnt = '0;
                end else if (apfHit) begin
                    next_pfState = PF_HOLD;
                    next_pfCnt = '0;
                end
            end
            PF_HOLD: begin
                if (holdDone && !pfStage1) begin
                    next_pfState = PF_RELEASE;
                    next_pfCnt = '0;
                end else if (holdDone) begin
                    next_pfCnt = pfCnt;
                end
            end
            PF_RELEASE: begin
                if (pfStage1) begin
                    // Power dropped again before release
                    next_pfState = PF_HOLD;
                    next_pfCnt = PF_CNT_W'(PfHoldCyc - 1);
                end else if (offDone) begin
                    next_pfState = PF_IDLE;
                    next_pfCnt = '0;
                end
            end
            default: begin
                next_pfState = PF_IDLE;
                next_pfCnt = '0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            pfState <= PF_IDLE;
            pfCnt <= '0;
        end else begin
            pfState <= next_pfState;
            pfCnt <= next_pfCnt;
        end
    end

    // Indication decode
    wire pfApf = (pfState == PF_HOLD) || (pfState == PF_RELEASE);
    wire pfRx = pfApf || (pfState == PF_RXMOD);

    // Output selection: polarity on data first, then modulation over data
    wire rxData = outLevel ^ invertRx;
    wire next_rxOut = !active ? invertRx : ((modMode && pfRx) ? 1'b1 : rxData);

    // Registered outputs toward controller and line
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            receive_line_out <= 1'b0;
            line_power_fail_out <= 1'b0;
            lineRxEnable <= 1'b1;
            loopback_delay_setting <= LB_CODE_RESET;
            unusedPinOut <= '0;
            unusedPinOe <= '0;
        end else begin
            receive_line_out <= next_rxOut;
            line_power_fail_out <= active && pfApf;
            lineRxEnable <= rxGate;
            loopback_delay_setting <= delayCode;
            unusedPinOut <= '1;
            unusedPinOe <= '0;
        end
    end

endmodule

`default_nettype wire

// [sim/asimpb_bridge_sva.sv]
// Port checker for the AS-i master bridge
`timescale 1ns/1ps
`default_nettype none
module asimpb_bridge_chk
    import asimpb_pkg::*;
#(
    parameter int PfApfCyc = PF_APF_CYC,
    parameter int PfOffCyc = PF_OFF_CYC
) (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ext_reset_low,
    // Configuration
    input wire asimpb_cfg_type cfgIn,
    input wire logic delayWrite,
    input wire logic [3:0] delay_code_bits,
    input wire logic [3:0] loopback_delay_setting,
    input wire logic writeRefused,
    // Line and controller
    input wire logic transmit_line_in,
    input wire logic lineTxOut,
    input wire logic lineRxEnable,
    input wire logic line_positive_input,
    input wire logic receive_line_out,
    input wire logic line_power_fail_out,
    input wire logic [UNUSED_PINS-1:0] unusedPinOut,
    input wire logic [UNUSED_PINS-1:0] unusedPinOe
);
    int hiCnt; // Raw comparator high run
    int loCnt; // Raw comparator low run
    default clocking @(posedge clk_sys); endclocking
    // Pin reset lags by its synchroniser, so both resets disable
    default disable iff (!reset_n || !ext_reset_low);
    // Run lengths of the comparator
    always_ff @(posedge clk_sys) begin
        hiCnt <= (reset_n && line_positive_input) ? hiCnt + 1 : 0;
        loCnt <= (reset_n && !line_positive_input) ? loCnt + 1 : 0;
    end
    chk_tx_pass: assert property (lineTxOut == transmit_line_in)
        else $error("transmit not passed");
    chk_unused_oe: assert property (unusedPinOe == '0)
        else $error("unused pin driven");
    chk_unused_high: assert property (unusedPinOut != '0 |-> unusedPinOut == '1)
        else $error("unused pin not high");
    chk_write_take: assert property (delayWrite && !cfgIn.masterEnable
        |-> ##2 loopback_delay_setting == $past(delay_code_bits, 2)) else $error("code not stored");
    chk_refuse_pulse: assert property (delayWrite && cfgIn.masterEnable |=> writeRefused)
        else $error("no refusal");
    chk_refuse_keep: assert property (delayWrite && cfgIn.masterEnable
        |-> ##2 $stable(loopback_delay_setting)) else $error("refused write stored");
    chk_rx_gate: assert property (cfgIn.masterEnable && cfgIn.mode == MODE_REPEATER
        && $changed(transmit_line_in) |-> ##[1:5] !lineRxEnable) else $error("receiver on");
    chk_pf_rx: assert property (cfgIn.masterEnable && cfgIn.mode == MODE_MASTER1
        && $rose(line_power_fail_out) |-> receive_line_out) else $error("receive not high");
    chk_pf_on: assert property ($rose(line_power_fail_out) |-> hiCnt >= PF_FILT_CYC + PfApfCyc - 1
        && hiCnt <= PF_FILT_CYC + PfApfCyc + 8) else $error("power fail timing");
    chk_pf_hold: assert property ($rose(line_power_fail_out) |=> line_power_fail_out [*8])
        else $error("hold too short");
    chk_pf_off: assert property (cfgIn.masterEnable && $fell(line_power_fail_out)
        |-> loCnt >= PF_FILT_CYC + PfOffCyc - 1) else $error("early release");
    cover property ($rose(line_power_fail_out));
    cover property (writeRefused);
    cover property (!lineRxEnable);
endmodule
bind asimpb_bridge asimpb_bridge_chk #(.PfApfCyc(PfApfCyc), .PfOffCyc(PfOffCyc)) i_chk (
    .clk_sys, .reset_n, .ext_reset_low, .cfgIn, .delayWrite, .delay_code_bits,
    .loopback_delay_setting, .writeRefused, .transmit_line_in, .lineTxOut, .lineRxEnable,
    .line_positive_input, .receive_line_out, .line_power_fail_out, .unusedPinOut, .unusedPinOe);
`default_nettype wire

// [sim/asimpb_line_model.sv]
// Line model: bus traffic to the receiver, supply to the comparator
`timescale 1ns/1ps
`default_nettype none
module asimpb_line_model (
    // Clock
    input wire logic clk_sys,
    // Device line pins
    input wire logic lineTxOut,
    input wire logic lineRxEnable,
    output logic lineRxIn,
    output logic line_positive_input,
    // Bench stimulus
    input wire logic busLevel,
    input wire logic powerLow
);
    logic noise = 1'h0; // Junk from a disabled receiver
    // A disabled receiver toggles every clock instead of showing the bus level
    always @(posedge clk_sys) noise <= ~noise;
    assign lineRxIn = lineRxEnable ? (busLevel | lineTxOut) : noise;
    // Comparator high while supply sits below threshold
    assign line_positive_input = powerLow;
endmodule
`default_nettype wire

// [sim/asimpb_bridge_test.sv]
// Self-checking bench for the AS-i master bridge
`timescale 1ns/1ps
`default_nettype none
module asimpb_bridge_test
    import asimpb_pkg::*;
;
    logic clk_sys, reset_n, ext_reset_low, delayWrite, txIn, busLevel, powerLow;
    logic txLine, rxIn, rxEn, cmp, rxOut, pfOut, refused;
    asimpb_cfg_type cfg; // Mode bundle
    logic [3:0] code, setting; // Delay code in and out
    logic [7:0] pinOut, pinOe; // Unused pins
    int n_fail = 0;
    int n_tests = 0;
    // Long power-fail counts shortened to keep the run brief
    asimpb_bridge #(.PfRxCyc(60), .PfApfCyc(70), .PfHoldCyc(20), .PfOffCyc(30)) i_dut (
        .clk_sys, .reset_n, .ext_reset_low, .cfgIn(cfg), .delayWrite, .delay_code_bits(code),
        .loopback_delay_setting(setting), .writeRefused(refused), .transmit_line_in(txIn),
        .lineTxOut(txLine), .lineRxIn(rxIn), .lineRxEnable(rxEn), .line_positive_input(cmp),
        .receive_line_out(rxOut), .line_power_fail_out(pfOut), .unusedPinIn(8'h00),
        .unusedPinOut(pinOut), .unusedPinOe(pinOe));
    asimpb_line_model i_line (.clk_sys, .lineTxOut(txLine), .lineRxEnable(rxEn),
        .lineRxIn(rxIn), .line_positive_input(cmp), .busLevel, .powerLow);
    // 100 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Count inside a window, else report it against the low bound
    task automatic span(input int n, input int lo, input int hi);
        check(12'(n), (n >= lo && n <= hi) ? 12'(n) : 12'(lo));
    endtask
    // Cycles until an output leaves its level, bounded
    task automatic waitFor(input bit pf, output int n);
        logic v;
        v = pf ? pfOut : rxOut;
        n = 0;
        while ((pf ? pfOut : rxOut) === v && n < 3000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic putCode(input logic [3:0] c);
        delayWrite = 1'h1;
        code = c;
        tick(1);
        delayWrite = 1'h0;
    endtask
    task automatic conclude;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reset values, code store, pin reset, refused write
    task automatic testConfig;
        check(pinOut, 8'hff);
        check(pinOe, 8'h00);
        check(pfOut, 1'h0);
        putCode(4'hf);
        tick(2);
        check(setting, 4'hf);
        ext_reset_low = 1'h0;
        tick(5);
        check(setting, 4'h0);
        ext_reset_low = 1'h1;
        tick(4);
        putCode(4'h3);
        cfg.masterEnable = 1'h1;
        tick(1);
        putCode(4'h6);
        check(refused, 1'h1);
        tick(3);
        check(refused, 1'h0);
        check(setting, 4'h3);
    endtask
    // Short dip ignored, then full power-fail cycle in mode one
    task automatic testPf;
        int n, m;
        powerLow = 1'h1;
        tick(500);
        powerLow = 1'h0;
        tick(800);
        check({rxOut, pfOut}, 2'h0);
        powerLow = 1'h1;
        waitFor(1'h0, n);
        span(n, 655, 675);
        check({rxOut, pfOut}, 2'h2);
        waitFor(1'h1, m);
        span(n + m, 665, 690);
        powerLow = 1'h0;
        tick(560);
        check(pfOut, 1'h1);
        waitFor(1'h1, n);
        span(n, 60, 85);
        tick(10);
        check(rxOut, 1'h0);
    endtask
    // Loopback delay at two codes, eight steps apart
    task automatic testLoop;
        int a, b;
        cfg.mode = MODE_MASTER2;
        tick(2);
        txIn = 1'h1;
        waitFor(1'h0, a);
        span(a, 490, 650);
        check(rxOut, 1'h1);
        txIn = 1'h0;
        tick(1500);
        cfg.masterEnable = 1'h0;
        putCode(4'hb);
        cfg.masterEnable = 1'h1;
        tick(1500);
        txIn = 1'h1;
        waitFor(1'h0, b);
        check(12'(b - a), 12'h064);
        txIn = 1'h0;
        tick(1500);
    endtask
    // Pass-through and receiver gating in repeater mode
    task automatic testTx;
        cfg.mode = MODE_REPEATER;
        tick(1500);
        txIn = 1'h1;
        #1 check(txLine, 1'h1);
        tick(5);
        check(rxEn, 1'h0);
        txIn = 1'h0;
        #1 check(txLine, 1'h0);
        tick(1500);
        check(rxEn, 1'h1);
    endtask
    // Re-timed edge, then a bad spacing blanks later edges
    task automatic testRx;
        int n;
        busLevel = 1'h1;
        waitFor(1'h0, n);
        span(n, 100, 110);
        check(rxOut, 1'h0);
        busLevel = 1'h0;
        tick(300);
        busLevel = 1'h1;
        tick(500);
        check(rxOut, 1'h1);
    endtask
    initial begin
        reset_n = 1'h0;
        ext_reset_low = 1'h1;
        cfg = '{1'h0, MODE_MASTER1};
        delayWrite = 1'h0;
        code = 4'h0;
        txIn = 1'h0;
        busLevel = 1'h0;
        powerLow = 1'h0;
        tick(10);
        reset_n = 1'h1;
        tick(3);
        testConfig;
        testPf;
        testLoop;
        testTx;
        testRx;
        conclude;
    end
    // Watchdog, about three times the expected run
    initial begin
        #400us;
        n_fail++;
        conclude;
    end
endmodule
`default_nettype wire
